// file: rtl/bms_bridge_gen.sv
/*
  half-bridge pulse generator: 50 percent duty with fixed dead time.
  assumes enable and clock enable come from the sequencer on clk_sys.
*/
`default_nettype none
module bms_bridge_gen
  import bms_pkg::*;
(
  input wire logic    clk_sys,
  input wire logic    rstn,
  bms_drive_if.gen    drive
);
  logic [PHASE_W-1:0] phase_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      phase_q <= PHASE_ZERO;
    end else if (drive.clkEn) begin
      if (!drive.oscEnable || phase_q == PHASE_LAST) begin
        phase_q <= PHASE_ZERO;
      end else begin
        phase_q <= phase_q + 12'h001;
      end
    end
  end

  // outputs lag the phase by one cycle; both lag equally so dead time holds
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      drive.lowSide  <= 1'b0;
      drive.highSide <= 1'b0;
      drive.cycleEnd <= 1'b0;
    end else if (drive.clkEn) begin
      drive.lowSide  <= drive.oscEnable && (phase_q < LOW_END);
      drive.highSide <= drive.oscEnable && (phase_q >= HIGH_START) && (phase_q < HIGH_END);
      drive.cycleEnd <= drive.oscEnable && (phase_q == LOW_LAST);
    end
  end
endmodule // bms_bridge_gen
`default_nettype wire

// file: rtl/bms_drive_if.sv
/*
  carrier between the sequencer and its half-bridge pulse generator.
  assumes both ends share clk_sys.
*/
`default_nettype none
interface bms_drive_if;
  logic clkEn;
  logic oscEnable;
  logic lowSide;
  logic highSide;
  logic cycleEnd;
  modport gen (input clkEn, input oscEnable, output lowSide, output highSide, output cycleEnd);
  modport seq (output clkEn, output oscEnable, input lowSide, input highSide, input cycleEnd);
endinterface
`default_nettype wire

// file: rtl/bms_pkg.sv
/*
  shared constants and mode type for the ballast mode and fault sequencer.
  assumes a 100 MHz system clock; analogue thresholds live in outside comparators.
*/
`default_nettype none
package bms_pkg;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int DEAD_TIME_NS     = 1600;
  localparam int DEAD_CYCLES      = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // switching period; the bridge generator counts it out in clkEn-enabled clk_sys cycles, so clkEn also sets the drive frequency
  localparam int SWITCH_PERIOD_NS = 25000;
  localparam int PERIOD_CYCLES    = SWITCH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int HALF_CYCLES      = PERIOD_CYCLES / 2;
  localparam int PHASE_W          = 12;
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 12'h000;
  localparam logic [PHASE_W-1:0] LOW_END    = PHASE_W'(HALF_CYCLES - DEAD_CYCLES);
  localparam logic [PHASE_W-1:0] LOW_LAST   = PHASE_W'(HALF_CYCLES - DEAD_CYCLES - 1);
  localparam logic [PHASE_W-1:0] HIGH_START = PHASE_W'(HALF_CYCLES);
  localparam logic [PHASE_W-1:0] HIGH_END   = PHASE_W'(PERIOD_CYCLES - DEAD_CYCLES);
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(PERIOD_CYCLES - 1);

  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] CNT_ZERO          = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE           = 7'h01;
  localparam logic [CNT_W-1:0] FAULT_EVENT_LIMIT = 7'h41;

  // comparator input positions in the synchronised vector
  localparam int NUM_CMP      = 10;
  localparam int CMP_VCC_ON   = 0;
  localparam int CMP_VCC_LOW  = 1;
  localparam int CMP_PH_RUN   = 2;
  localparam int CMP_PH_THIRD = 3;
  localparam int CMP_OC       = 4;
  localparam int CMP_BUS_UV   = 5;
  localparam int CMP_WIN_HI   = 6;
  localparam int CMP_WIN_LO   = 7;
  localparam int CMP_SD_REM   = 8;
  localparam int CMP_SD_INS   = 9;
  localparam logic [NUM_CMP-1:0] CMP_RESET = 10'h000;

  typedef enum logic [2:0] {
    MD_LOCKOUT,
    MD_PREHEAT,
    MD_IGNITION,
    MD_RUN,
    MD_FAULT,
    MD_BROWNOUT
  } bms_mode_t;
endpackage
`default_nettype wire

// file: rtl/bms_sequencer.sv
/*
  ballast mode sequencer and fault supervisor: lockout, preheat, ignition, run,
  fault and bus brown-out, with the up/down bridge over-current counter.
  assumes all threshold inputs are asynchronous comparator outputs and that
  lockout of the supply is reported by the supply comparators.
*/
`default_nettype none
module bms_sequencer
  import bms_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic clkEn,
  input  wire logic supplyAboveStart,
  input  wire logic supplyBelowLockout,
  input  wire logic preheatAboveRunLevel,
  input  wire logic preheatBelowThird,
  input  wire logic bridgeOverCurrent,
  input  wire logic busUnderVoltage,
  input  wire logic windowAboveUpper,
  input  wire logic windowBelowLower,
  input  wire logic shutdownAboveRemoval,
  input  wire logic shutdownBelowReinsertion,
  output wire logic highSideDrive,
  output wire logic lowSideDrive,
  output wire logic boostGateEnable,
  output wire logic boostHighGain,
  output wire logic preheatDischarge,
  output wire logic preheatDropToThird,
  output wire logic rampDischarge,
  output wire logic rampRaise,
  output wire logic supplyDischarge
);
  bms_drive_if drive ();

  bms_mode_t            mode_q;
  bms_mode_t            mode_d;
  logic [NUM_CMP-1:0]   cmpRaw;
  logic [NUM_CMP-1:0]   sync1_q;
  logic [NUM_CMP-1:0]   sync2_q;
  logic [NUM_CMP-1:0]   sync3_q;
  logic [NUM_CMP-1:0]   cmp_q;
  logic                 runLevelPrev_q;
  logic                 runEdge;
  logic                 dropping_q;
  logic                 restartArmed_q;
  logic                 ocSeen_q;
  logic                 ocThisCycle;
  logic [CNT_W-1:0]     faultCount_q;
  logic                 countEnable;
  logic                 limitHit;
  logic                 oscEnable_q;
  logic                 highSide_q;
  logic                 lowSide_q;
  logic                 boostEnable_q;
  logic                 highGain_q;
  logic                 phDischarge_q;
  logic                 phDrop_q;
  logic                 rampDischarge_q;
  logic                 rampRaise_q;
  logic                 supplyDischarge_q;

  // modes in which the oscillator runs and the gates may switch
  function automatic logic drivesAllowed(input bms_mode_t m);
    drivesAllowed = (m == MD_PREHEAT) || (m == MD_IGNITION) || (m == MD_RUN);
  endfunction

  assign cmpRaw = {shutdownBelowReinsertion, shutdownAboveRemoval, windowBelowLower,
                   windowAboveUpper, busUnderVoltage, bridgeOverCurrent, preheatBelowThird,
                   preheatAboveRunLevel, supplyBelowLockout, supplyAboveStart};

  // three stages; a change is accepted only once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync1_q <= CMP_RESET;
      sync2_q <= CMP_RESET;
      sync3_q <= CMP_RESET;
    end else if (clkEn) begin
      sync1_q <= cmpRaw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          cmp_q[gi] <= 1'b0;
        end else if (clkEn && (sync2_q[gi] == sync3_q[gi])) begin
          cmp_q[gi] <= sync3_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      runLevelPrev_q <= 1'b0;
    end else if (clkEn) begin
      runLevelPrev_q <= cmp_q[CMP_PH_RUN];
    end
  end

  assign runEdge = cmp_q[CMP_PH_RUN] && !runLevelPrev_q;

  // over-current counts only while the low side conducts
  assign ocThisCycle = ocSeen_q || (drive.lowSide && cmp_q[CMP_OC]);
  assign countEnable = (mode_q == MD_PREHEAT) || (mode_q == MD_RUN);
  assign limitHit    = countEnable && drive.cycleEnd && ocThisCycle
                       && (faultCount_q == FAULT_EVENT_LIMIT - CNT_ONE);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ocSeen_q <= 1'b0;
    end else if (clkEn) begin
      if (drive.cycleEnd) begin
        ocSeen_q <= 1'b0;
      end else if (drive.lowSide && cmp_q[CMP_OC]) begin
        ocSeen_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      faultCount_q <= CNT_ZERO;
    end else if (clkEn) begin
      if (!countEnable || mode_d == MD_LOCKOUT || mode_d == MD_FAULT) begin
        faultCount_q <= CNT_ZERO;
      end else if (drive.cycleEnd) begin
        if (ocThisCycle) begin
          faultCount_q <= faultCount_q + CNT_ONE;
        end else if (faultCount_q != CNT_ZERO) begin
          faultCount_q <= faultCount_q - CNT_ONE;
        end
      end
    end
  end

  always_comb begin
    mode_d = mode_q;
    if (cmp_q[CMP_VCC_LOW] && mode_q != MD_LOCKOUT) begin
      mode_d = MD_LOCKOUT;
    end else begin
      case (mode_q)
        MD_LOCKOUT: begin
          if (cmp_q[CMP_VCC_ON] && restartArmed_q && cmp_q[CMP_SD_INS]) begin
            mode_d = MD_PREHEAT;
          end
        end
        MD_PREHEAT: begin
          if (limitHit) begin
            mode_d = MD_FAULT;
          end else if (dropping_q && cmp_q[CMP_PH_THIRD]) begin
            mode_d = MD_IGNITION;
          end
        end
        MD_IGNITION: begin
          // window and counter are not looked at here
          if (runEdge) begin
            mode_d = MD_RUN;
          end
        end
        MD_RUN: begin
          if (cmp_q[CMP_BUS_UV]) begin
            mode_d = MD_BROWNOUT;
          end else if (limitHit) begin
            mode_d = MD_FAULT;
          end else if (cmp_q[CMP_WIN_HI] || cmp_q[CMP_WIN_LO]) begin
            mode_d = MD_FAULT;
          end
        end
        MD_FAULT: begin
          if (cmp_q[CMP_SD_REM]) begin
            mode_d = MD_LOCKOUT;
          end
        end
        MD_BROWNOUT: begin
          mode_d = MD_BROWNOUT;
        end
        default: begin
          mode_d = MD_LOCKOUT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_q <= MD_LOCKOUT;
    end else if (clkEn) begin
      mode_q <= mode_d;
    end
  end

  // first crossing starts the quick drop to a third of supply
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dropping_q <= 1'b0;
    end else if (clkEn) begin
      if (mode_d != MD_PREHEAT) begin
        dropping_q <= 1'b0;
      end else if (runEdge) begin
        dropping_q <= 1'b1;
      end
    end
  end

  // power-up needs only a low shutdown input; after a fault the lamp must be
  // removed and put back before preheat starts again
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      restartArmed_q <= 1'b1;
    end else if (clkEn) begin
      if (mode_q == MD_FAULT && mode_d == MD_LOCKOUT) begin
        restartArmed_q <= 1'b0;
      end else if (mode_q == MD_LOCKOUT && cmp_q[CMP_SD_REM]) begin
        restartArmed_q <= 1'b1;
      end
    end
  end

  // outputs follow the next mode so they change in the same cycle as the mode
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      oscEnable_q     <= 1'b0;
      highSide_q      <= 1'b0;
      lowSide_q       <= 1'b0;
      boostEnable_q   <= 1'b0;
      highGain_q      <= 1'b0;
      phDischarge_q   <= 1'b1;
      phDrop_q        <= 1'b0;
      rampDischarge_q <= 1'b1;
    end else if (clkEn) begin
      oscEnable_q     <= drivesAllowed(mode_d);
      highSide_q      <= drivesAllowed(mode_d) && drive.highSide;
      lowSide_q       <= drivesAllowed(mode_d) && drive.lowSide;
      boostEnable_q   <= drivesAllowed(mode_d);
      highGain_q      <= (mode_d == MD_PREHEAT) || (mode_d == MD_IGNITION);
      phDischarge_q   <= !drivesAllowed(mode_d);
      phDrop_q        <= (mode_d == MD_PREHEAT) && (dropping_q || runEdge)
                         && !cmp_q[CMP_PH_THIRD];
      rampDischarge_q <= (mode_d != MD_IGNITION) && (mode_d != MD_RUN);
    end
  end

  // one raise per over-current cycle, only while ignition lasts
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rampRaise_q <= 1'b0;
    end else if (clkEn) begin
      if (mode_d != MD_IGNITION) begin
        rampRaise_q <= 1'b0;
      end else if (drive.cycleEnd) begin
        rampRaise_q <= ocThisCycle;
      end
    end
  end

  // the supply pull-down stays on until the supply itself reaches lockout
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      supplyDischarge_q <= 1'b0;
    end else if (clkEn) begin
      supplyDischarge_q <= (mode_d == MD_BROWNOUT);
    end
  end

  assign drive.clkEn     = clkEn;
  assign drive.oscEnable = oscEnable_q;

  bms_bridge_gen u_gen (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .drive   (drive)
  );

  assign highSideDrive      = highSide_q;
  assign lowSideDrive       = lowSide_q;
  assign boostGateEnable    = boostEnable_q;
  assign boostHighGain      = highGain_q;
  assign preheatDischarge   = phDischarge_q;
  assign preheatDropToThird = phDrop_q;
  assign rampDischarge      = rampDischarge_q;
  assign rampRaise          = rampRaise_q;
  assign supplyDischarge    = supplyDischarge_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence firstCrossing;
    clkEn && mode_q == MD_PREHEAT && !dropping_q && runEdge && !limitHit
      && !cmp_q[CMP_VCC_LOW] && !cmp_q[CMP_PH_THIRD];
  endsequence

  sequence dropStarted;
    dropping_q && preheatDropToThird && mode_q == MD_PREHEAT;
  endsequence

  drop_third_a: assert property (firstCrossing |=> dropStarted)
    else $error("first crossing did not start the drop to a third");

  ign_to_run_a: assert property (clkEn && mode_q == MD_IGNITION && runEdge
      && !cmp_q[CMP_VCC_LOW] |=> mode_q == MD_RUN)
    else $error("second crossing did not enter run");

  ign_holds_a: assert property (clkEn && mode_q == MD_IGNITION && !runEdge
      && !cmp_q[CMP_VCC_LOW] |=> mode_q == MD_IGNITION)
    else $error("ignition left without second crossing");

  run_no_raise_a: assert property (mode_q == MD_RUN |-> !rampRaise)
    else $error("ramp raised in run");

  high_gain_a: assert property (mode_q == MD_IGNITION |-> boostHighGain)
    else $error("boost not in high gain during ignition");

  limit_fault_a: assert property (clkEn && mode_q == MD_RUN && limitHit
      && !cmp_q[CMP_VCC_LOW] && !cmp_q[CMP_BUS_UV] |=> mode_q == MD_FAULT)
    else $error("event limit did not enter fault");

  window_fault_a: assert property (clkEn && mode_q == MD_RUN && !cmp_q[CMP_VCC_LOW]
      && !cmp_q[CMP_BUS_UV] && (cmp_q[CMP_WIN_HI] || cmp_q[CMP_WIN_LO])
      |=> mode_q == MD_FAULT)
    else $error("window violation did not enter fault");

  brownout_a: assert property (clkEn && mode_q == MD_RUN && cmp_q[CMP_BUS_UV]
      && !cmp_q[CMP_VCC_LOW] |=> supplyDischarge && !highSideDrive
      && !lowSideDrive && !boostGateEnable)
    else $error("bus undervoltage did not discharge supply");

  fault_outputs_a: assert property (mode_q == MD_FAULT |-> !highSideDrive && !lowSideDrive
      && !boostGateEnable && preheatDischarge && rampDischarge)
    else $error("fault mode outputs wrong");

  lockout_outputs_a: assert property (mode_q == MD_LOCKOUT |-> !highSideDrive
      && !lowSideDrive && preheatDischarge && !drive.oscEnable)
    else $error("lockout outputs wrong");

  count_down_a: assert property (clkEn && countEnable && drive.cycleEnd && !ocThisCycle
      && faultCount_q != CNT_ZERO && mode_d == mode_q
      |=> faultCount_q == $past(faultCount_q) - CNT_ONE)
    else $error("counter did not count down on a clean cycle");

  no_overlap_a: assert property (!(highSideDrive && lowSideDrive))
    else $error("bridge drives overlap");
endmodule // bms_sequencer
`default_nettype wire

// file: tb/bms_lamp_model.sv
/*
  far-side model: preheat timing capacitor, bridge current sense.
  assumes sequencer outputs on clk_sys; the bench commands over-current and charge hold.
*/
`default_nettype none
module bms_lamp_model (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic preheatDischarge,
  input  wire logic preheatDropToThird,
  input  wire logic lowSideDrive,
  input  wire logic ocMode,
  input  wire logic holdCharge,
  output var  logic preheatAboveRunLevel,
  output var  logic preheatBelowThird,
  output var  logic bridgeOverCurrent
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LVL_THIRD = 500;
  localparam int LVL_RUN   = 1000;
  localparam int LVL_FULL  = 1500;
  int capLevel;
  always_ff @(posedge clk_sys) begin
    if (!rstn || preheatDischarge) begin
      capLevel <= 0;
    end else if (preheatDropToThird) begin
      capLevel <= (capLevel > 5) ? capLevel - 5 : 0;
    end else if (!holdCharge && capLevel < LVL_FULL) begin
      // hold stretches ignition so several switching cycles fit inside it
      capLevel <= capLevel + 1;
    end
  end
  assign preheatAboveRunLevel = (capLevel >= LVL_RUN);
  assign preheatBelowThird    = (capLevel <= LVL_THIRD);
  // sense resistor sits under the low-side switch, so current shows only while it conducts
  assign bridgeOverCurrent    = ocMode & lowSideDrive;
endmodule // bms_lamp_model
`default_nettype wire

// file: tb/bms_sequencer_tb.sv
/*
  self-checking bench for the ballast mode sequencer with the lamp model.
  assumes the sequencer package and its registered outputs; clock enable held high except during the freeze in the run test.
*/
`default_nettype none
module bms_sequencer_tb
  import bms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int O_HI = 8, O_LO = 7, O_BG = 6, O_HG = 5, O_PD = 4;
  localparam int O_DT = 3, O_RD = 2, O_RR = 1, O_SD = 0;
  logic clk_sys = 1'b0, rstn = 1'b0, supplyAboveStart = 1'b0, supplyBelowLockout = 1'b0;
  logic busUnderVoltage = 1'b0, windowAboveUpper = 1'b0, windowBelowLower = 1'b0;
  logic shutdownAboveRemoval = 1'b0, shutdownBelowReinsertion = 1'b0;
  logic ocMode = 1'b0, holdCharge = 1'b0, clkEn = 1'b1;
  wire logic preheatAboveRunLevel, preheatBelowThird, bridgeOverCurrent;
  wire logic highSideDrive, lowSideDrive, boostGateEnable, boostHighGain, preheatDischarge;
  wire logic preheatDropToThird, rampDischarge, rampRaise, supplyDischarge;
  wire logic [8:0] obs;
  int fail_count = 0;
  int num_checks = 0;
  assign obs = {highSideDrive, lowSideDrive, boostGateEnable, boostHighGain, preheatDischarge,
                preheatDropToThird, rampDischarge, rampRaise, supplyDischarge};
  always #5 clk_sys = ~clk_sys;

  bms_sequencer i_dut (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn),
    .supplyAboveStart(supplyAboveStart), .supplyBelowLockout(supplyBelowLockout),
    .preheatAboveRunLevel(preheatAboveRunLevel), .preheatBelowThird(preheatBelowThird),
    .bridgeOverCurrent(bridgeOverCurrent), .busUnderVoltage(busUnderVoltage),
    .windowAboveUpper(windowAboveUpper), .windowBelowLower(windowBelowLower),
    .shutdownAboveRemoval(shutdownAboveRemoval),
    .shutdownBelowReinsertion(shutdownBelowReinsertion),
    .highSideDrive(highSideDrive), .lowSideDrive(lowSideDrive),
    .boostGateEnable(boostGateEnable), .boostHighGain(boostHighGain),
    .preheatDischarge(preheatDischarge), .preheatDropToThird(preheatDropToThird),
    .rampDischarge(rampDischarge), .rampRaise(rampRaise), .supplyDischarge(supplyDischarge));

  bms_lamp_model i_lamp (.clk_sys(clk_sys), .rstn(rstn), .preheatDischarge(preheatDischarge),
    .preheatDropToThird(preheatDropToThird), .lowSideDrive(lowSideDrive), .ocMode(ocMode),
    .holdCharge(holdCharge), .preheatAboveRunLevel(preheatAboveRunLevel),
    .preheatBelowThird(preheatBelowThird), .bridgeOverCurrent(bridgeOverCurrent));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chkBit(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic chkNum(input int got, input int exp, input string msg);
    num_checks++;
    if (got != exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %0d", $time, msg, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic waitSig(input int idx, input logic val, input int lim, input string msg);
    int n;
    n = 0;
    while (obs[idx] !== val && n < lim) begin
      tick(1);
      n++;
    end
    if (obs[idx] !== val) begin
      fail_count++;
      $display("[FAIL] %0t timeout %s", $time, msg);
      summarize();
    end
  endtask

  task automatic endTest(input string name);
    $display("test %s done, mismatches so far %0d", name, fail_count);
  endtask

  task automatic testReset();
    chkBit(obs[O_HI] | obs[O_LO] | obs[O_BG], 1'b0, "gates on in reset");
    chkBit(obs[O_PD] & obs[O_RD], 1'b1, "timing inputs not grounded");
    chkBit(obs[O_SD], 1'b0, "supply discharge in reset");
    endTest("reset");
  endtask

  task automatic testPreheat();
    int hiLen;
    int gap;
    hiLen = 0;
    gap = 0;
    @(posedge clk_sys);
    // hold keeps preheat alive for a whole switching period; ignition would start otherwise
    holdCharge <= 1'b1;
    supplyAboveStart <= 1'b1;
    shutdownBelowReinsertion <= 1'b1;
    waitSig(O_PD, 1'b0, 20, "preheat entry");
    chkBit(obs[O_HG] & obs[O_BG], 1'b1, "boost not high gain in preheat");
    @(posedge clk_sys);
    busUnderVoltage <= 1'b1;
    tick(20);
    chkBit(obs[O_SD], 1'b0, "bus undervoltage acted outside run");
    @(posedge clk_sys);
    busUnderVoltage <= 1'b0;
    waitSig(O_LO, 1'b1, 2600, "low side start");
    waitSig(O_LO, 1'b0, 2600, "low side end");
    waitSig(O_LO, 1'b1, 2600, "low side again");
    while (obs[O_LO] === 1'b1 && hiLen < 3000) begin
      tick(1);
      hiLen++;
    end
    while (obs[O_HI] !== 1'b1 && gap < 3000) begin
      tick(1);
      gap++;
    end
    chkNum(hiLen, int'(LOW_END), "low side on time");
    chkNum(gap, DEAD_CYCLES, "dead time");
    @(posedge clk_sys);
    holdCharge <= 1'b0;
    endTest("preheat");
  endtask

  task automatic testIgnition();
    waitSig(O_DT, 1'b1, 1500, "drop to third");
    waitSig(O_RD, 1'b0, 300, "ignition entry");
    chkBit(obs[O_HG], 1'b1, "boost not high gain in ignition");
    @(posedge clk_sys);
    holdCharge <= 1'b1;
    windowAboveUpper <= 1'b1;
    ocMode <= 1'b1;
    waitSig(O_RR, 1'b1, 3000, "ramp raise");
    chkBit(obs[O_BG] & ~obs[O_RD], 1'b1, "fault taken in ignition");
    @(posedge clk_sys);
    ocMode <= 1'b0;
    windowAboveUpper <= 1'b0;
    waitSig(O_RR, 1'b0, 6000, "ramp raise release");
    chkBit(obs[O_BG], 1'b1, "counter active in ignition");
    @(posedge clk_sys);
    holdCharge <= 1'b0;
    endTest("ignition");
  endtask

  task automatic testRun();
    logic raised;
    logic [8:0] snap;
    raised = 1'b0;
    waitSig(O_HG, 1'b0, 1500, "run entry");
    chkBit(obs[O_PD] | obs[O_RD], 1'b0, "timing inputs held in run");
    @(posedge clk_sys);
    ocMode <= 1'b1;
    repeat (7500) begin
      tick(1);
      raised = raised | rampRaise;
    end
    @(posedge clk_sys);
    ocMode <= 1'b0;
    chkBit(raised, 1'b0, "ramp raised in run");
    chkBit(obs[O_BG], 1'b1, "few events faulted");
    // clean cycles let the counter step down before the freeze
    tick(2600);
    @(posedge clk_sys);
    clkEn <= 1'b0;
    tick(1);
    snap = obs;
    tick(2600);
    chkBit(obs === snap, 1'b1, "outputs moved while clock disabled");
    @(posedge clk_sys);
    clkEn <= 1'b1;
    endTest("run");
  endtask

  task automatic testWindowFault();
    logic gateSeen;
    gateSeen = 1'b0;
    @(posedge clk_sys);
    windowBelowLower <= 1'b1;
    waitSig(O_BG, 1'b0, 8, "window fault");
    chkBit(obs[O_HI] | obs[O_LO], 1'b0, "bridge on in fault");
    chkBit(obs[O_PD] & obs[O_RD], 1'b1, "timing inputs kept in fault");
    @(posedge clk_sys);
    windowBelowLower <= 1'b0;
    repeat (3000) begin
      tick(1);
      gateSeen = gateSeen | highSideDrive | lowSideDrive | boostGateEnable;
    end
    chkBit(gateSeen, 1'b0, "fault not latched");
    endTest("window fault");
  endtask

  task automatic testRestart();
    @(posedge clk_sys);
    shutdownAboveRemoval <= 1'b1;
    shutdownBelowReinsertion <= 1'b0;
    tick(20);
    @(posedge clk_sys);
    shutdownAboveRemoval <= 1'b0;
    tick(50);
    chkBit(obs[O_PD], 1'b1, "restart before reinsertion");
    @(posedge clk_sys);
    shutdownBelowReinsertion <= 1'b1;
    waitSig(O_PD, 1'b0, 10, "restart after reinsertion");
    endTest("restart");
  endtask

  task automatic testBrownout();
    waitSig(O_DT, 1'b1, 1500, "second drop");
    waitSig(O_HG, 1'b0, 3000, "second run");
    @(posedge clk_sys);
    busUnderVoltage <= 1'b1;
    waitSig(O_SD, 1'b1, 8, "supply discharge");
    chkBit(obs[O_HI] | obs[O_LO] | obs[O_BG], 1'b0, "gates on in brownout");
    @(posedge clk_sys);
    supplyBelowLockout <= 1'b1;
    supplyAboveStart <= 1'b0;
    busUnderVoltage <= 1'b0;
    waitSig(O_SD, 1'b0, 8, "lockout after brownout");
    chkBit(obs[O_PD], 1'b1, "preheat input not grounded");
    @(posedge clk_sys);
    supplyBelowLockout <= 1'b0;
    supplyAboveStart <= 1'b1;
    waitSig(O_PD, 1'b0, 10, "power-up restart");
    endTest("brownout");
  endtask

  // the 65-event limit needs over 160k cycles here, so it is left to the design's assertions
  initial begin
    repeat (7) @(posedge clk_sys);
    #1;
    testReset();
    @(posedge clk_sys);
    rstn <= 1'b1;
    testPreheat();
    testIgnition();
    testRun();
    testWindowFault();
    testRestart();
    testBrownout();
    summarize();
  end
endmodule // bms_sequencer_tb
`default_nettype wire
